// ---- supervisor_map.svh ----
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH
`define SYS_CLK_MHZ           100
`define TIMEOUT_MS            210
`define TIMEOUT_CYC           (`TIMEOUT_MS * 1000 * `SYS_CLK_MHZ)
`define SETUP_K_MS            10080
`define SETUP_L_MS            6720
`define SETUP_S_MS            3360
`define SETUP_T_MS            1680
`define IMM_QUAL_NS           1000
`define IMM_QUAL_CYC          ((`IMM_QUAL_NS * `SYS_CLK_MHZ) / 1000)
`define IMM_GLITCH_NS         100
`define IMM_GLITCH_CYC        ((`IMM_GLITCH_NS * `SYS_CLK_MHZ + 999) / 1000)
`define IMM_FALL_MS           210
`define IMM_FALL_CYC          (`IMM_FALL_MS * 1000 * `SYS_CLK_MHZ)
`define TICK_CYC              100000
`define CNT_W                 32
`endif

// ---- supervisor_pkg.sv ----
`default_nettype none
package supervisor_pkg;
    typedef enum logic [2:0] {
        VAR_SINGLE    = 3'h1,
        VAR_DUAL      = 3'h2,
        VAR_IMMEDIATE = 3'h4
    } variant_e;
    typedef enum logic [1:0] {
        SETUP_K = 2'h0,
        SETUP_L = 2'h1,
        SETUP_S = 2'h2,
        SETUP_T = 2'h3
    } setup_opt_e;
    typedef enum logic [2:0] {
        HOLD_IDLE  = 3'h1,
        HOLD_COUNT = 3'h2,
        HOLD_SPENT = 3'h4
    } hold_state_e;
    typedef logic [31:0] cnt_t;
endpackage
`default_nettype wire

// ---- pulse_timer.sv ----
`default_nettype none
`include "supervisor_map.svh"
// Counts down a load value; busy while nonzero; a new load restarts it.
module pulse_timer
    import supervisor_pkg::*;
(
    // Clock and reset.
    input  wire  logic sys_clk_i,
    input  wire  logic srst_i,
    // Control.
    input  wire  logic load_i,
    input  wire  cnt_t load_val_i,
    // Status.
    output var   logic busy_o
);
    cnt_t cnt_q;
    cnt_t cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = load_val_i;
        end else if (cnt_q != 32'h0) begin
            cnt_d = cnt_q - 32'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy_o = (cnt_q != 32'h0);
endmodule // pulse_timer
`default_nettype wire

// ---- supervisor_manual_reset_timer.sv ----
// Contract
// (R1) Any low supply flag asserts reset.
// (R2) Hold reset one timeout after supplies recover.
// (R3) Full setup hold low emits one pulse.
// (R4) Short low intervals produce no reset.
// (R5) Setup period chosen from four options.
// (R6) Dual variant needs both inputs low.
// (R7) Immediate rising edge starts pulse directly.
// (R8) Immediate input qualified, glitches rejected, fast.
// (R9) Manual pulse lasts the manual timeout.
// (R10) Reset output is active low.
// (R11) Rearm only after a release then hold.
// (R12) New immediate edge restarts the timeout.
// (R13) Immediate falling edge filtered about 210 ms.
// (R14) Output ORs supply hold and manual pulse.
// (R15) Undriven long-hold input reads inactive.
`default_nettype none
`include "supervisor_map.svh"
module supervisor_manual_reset_timer
    import supervisor_pkg::*;
#(
    parameter variant_e   VARIANT      = VAR_SINGLE,
    parameter setup_opt_e SETUP_OPT    = SETUP_L,
    parameter cnt_t       TIMEOUT_CYC  = `TIMEOUT_CYC,
    parameter cnt_t       FALL_CYC     = `IMM_FALL_CYC,
    parameter cnt_t       TICK_CYC     = `TICK_CYC
)
(
    // Clock and reset.
    input  wire  logic sys_clk_i,
    input  wire  logic srst_i,
    // Supply comparators, high while a supply is below threshold.
    input  wire  logic vcc_under_i,
    input  wire  logic adjustable_monitor_input_under_i,
    // Manual inputs; long-hold inputs active low, driven value with drive flag.
    input  wire  logic long_hold_manual_input_a_n_i,
    input  wire  logic long_hold_manual_input_a_driven_i,
    input  wire  logic second_manual_input_i,
    input  wire  logic second_manual_input_driven_i,
    // Processor reset.
    output var   logic sys_reset_n_o
);
    // Setup period in millisecond ticks.
    function automatic cnt_t setup_ticks(input setup_opt_e opt);
        case (opt)
            SETUP_K: setup_ticks = cnt_t'(`SETUP_K_MS);
            SETUP_L: setup_ticks = cnt_t'(`SETUP_L_MS);
            SETUP_S: setup_ticks = cnt_t'(`SETUP_S_MS);
            SETUP_T: setup_ticks = cnt_t'(`SETUP_T_MS);
            default: setup_ticks = cnt_t'(`SETUP_L_MS);
        endcase
    endfunction

    localparam cnt_t HOLD_SETUP_PERIOD = setup_ticks(SETUP_OPT); // (R5)
    localparam cnt_t QUAL_CYC          = cnt_t'(`IMM_QUAL_CYC);
    localparam cnt_t GLITCH_CYC        = cnt_t'(`IMM_GLITCH_CYC);

    // Millisecond tick divider.
    cnt_t tick_cnt_q;
    cnt_t tick_cnt_d;
    logic ms_tick;

    always_comb begin
        tick_cnt_d = tick_cnt_q + 32'h1;
        if (tick_cnt_q >= TICK_CYC - 32'h1) begin
            tick_cnt_d = 32'h0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tick_cnt_q <= 32'h0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    assign ms_tick = (tick_cnt_q >= TICK_CYC - 32'h1);

    // Input conditioning.
    logic mr_a_low;
    logic mr_b_low;
    logic hold_cond;

    assign mr_a_low = long_hold_manual_input_a_driven_i & ~long_hold_manual_input_a_n_i; // (R15)
    assign mr_b_low = second_manual_input_driven_i & ~second_manual_input_i;             // (R15)

    always_comb begin
        case (VARIANT)
            VAR_DUAL: hold_cond = mr_a_low & mr_b_low; // (R6)
            default:  hold_cond = mr_a_low;
        endcase
    end

    // Long-hold detector.
    hold_state_e hold_st_q;
    hold_state_e hold_st_d;
    cnt_t        hold_cnt_q;
    cnt_t        hold_cnt_d;
    logic        hold_fire;

    always_comb begin
        hold_st_d  = hold_st_q;
        hold_cnt_d = hold_cnt_q;
        hold_fire  = 1'b0;
        case (hold_st_q)
            HOLD_IDLE: begin
                hold_cnt_d = 32'h0;
                if (hold_cond) begin
                    hold_st_d = HOLD_COUNT;
                end
            end
            HOLD_COUNT: begin
                if (!hold_cond) begin
                    hold_st_d = HOLD_IDLE; // (R4)
                end else if (ms_tick) begin
                    hold_cnt_d = hold_cnt_q + 32'h1;
                    if (hold_cnt_q + 32'h1 >= HOLD_SETUP_PERIOD) begin
                        hold_fire = 1'b1; // (R3)
                        hold_st_d = HOLD_SPENT;
                    end
                end
            end
            HOLD_SPENT: begin
                if (!hold_cond) begin
                    hold_st_d = HOLD_IDLE; // (R11)
                end
            end
            default: hold_st_d = HOLD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            hold_st_q  <= HOLD_IDLE;
            hold_cnt_q <= 32'h0;
        end else begin
            hold_st_q  <= hold_st_d;
            hold_cnt_q <= hold_cnt_d;
        end
    end

    // Immediate input: high-level qualifier and falling-edge filter.
    cnt_t imm_hi_q;
    cnt_t imm_hi_d;
    cnt_t imm_lo_q;
    cnt_t imm_lo_d;
    logic imm_state_q;
    logic imm_state_d;
    logic imm_fire;

    always_comb begin
        imm_hi_d    = 32'h0;
        imm_lo_d    = 32'h0;
        imm_state_d = imm_state_q;
        imm_fire    = 1'b0;
        if (VARIANT == VAR_IMMEDIATE) begin
            if (second_manual_input_i) begin
                imm_hi_d = (imm_hi_q >= QUAL_CYC) ? imm_hi_q : imm_hi_q + 32'h1;
                if (!imm_state_q && imm_hi_q + 32'h1 > GLITCH_CYC) begin
                    imm_state_d = 1'b1; // (R8)
                    imm_fire    = 1'b1; // (R7)
                end
            end else begin
                imm_lo_d = (imm_lo_q >= FALL_CYC) ? imm_lo_q : imm_lo_q + 32'h1;
                if (imm_state_q && imm_lo_q + 32'h1 >= FALL_CYC) begin
                    imm_state_d = 1'b0; // (R13)
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            imm_hi_q    <= 32'h0;
            imm_lo_q    <= 32'h0;
            imm_state_q <= 1'b0;
        end else begin
            imm_hi_q    <= imm_hi_d;
            imm_lo_q    <= imm_lo_d;
            imm_state_q <= imm_state_d;
        end
    end

    // Manual pulse timer; each trigger reloads it.
    logic manual_busy;

    pulse_timer u_manual_timer (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .load_i    (hold_fire | imm_fire), // (R12)
        .load_val_i(TIMEOUT_CYC),          // (R9)
        .busy_o    (manual_busy)
    );

    // Supply hold timer, reloaded every cycle a supply is low.
    logic supply_low;
    logic supply_busy;

    assign supply_low = vcc_under_i | adjustable_monitor_input_under_i; // (R1)

    pulse_timer u_supply_timer (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .load_i    (supply_low), // (R2)
        .load_val_i(TIMEOUT_CYC),
        .busy_o    (supply_busy)
    );

    // Output register.
    logic rst_n_q;
    logic rst_n_d;

    always_comb begin
        rst_n_d = ~(supply_low | supply_busy | manual_busy | imm_fire | hold_fire); // (R14)
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rst_n_q <= 1'b0;
        end else begin
            rst_n_q <= rst_n_d;
        end
    end

    assign sys_reset_n_o = rst_n_q; // (R10)
endmodule // supervisor_manual_reset_timer
`default_nettype wire

// ---- sup_assertions.sv ----
`default_nettype none
module sup_chk #(
    parameter int TIMEOUT_CYC = 50,
    parameter int FALL_CYC    = 40,
    parameter int TICK_CYC    = 2
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Watched pins.
    input wire logic vcc_under_i,
    input wire logic adjustable_monitor_input_under_i,
    input wire logic long_hold_manual_input_a_n_i,
    input wire logic long_hold_manual_input_a_driven_i,
    input wire logic second_manual_input_i,
    input wire logic sys_reset_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int   quiet_q;
    int   hi_q;
    int   lo_q;
    int   hold_q;
    logic arm_q;
    logic bad;
    logic idle;
    logic held;
    assign bad  = vcc_under_i | adjustable_monitor_input_under_i;
    assign idle = sys_reset_n_o & ~bad;
    assign held = long_hold_manual_input_a_driven_i & ~long_hold_manual_input_a_n_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            quiet_q <= TIMEOUT_CYC;
            hi_q    <= 0;
            lo_q    <= 0;
            hold_q  <= 0;
            arm_q   <= 1'b0;
        end else begin
            quiet_q <= bad ? 0 : (quiet_q < TIMEOUT_CYC ? quiet_q + 1 : quiet_q);
            hi_q    <= second_manual_input_i ? hi_q + 1 : 0;
            lo_q    <= second_manual_input_i ? 0 : (lo_q < FALL_CYC + 2 ? lo_q + 1 : lo_q);
            arm_q   <= second_manual_input_i ? arm_q : (lo_q >= FALL_CYC + 2);
            hold_q  <= held ? (hold_q < 1680 * TICK_CYC ? hold_q + 1 : hold_q) : 0;
        end
    end
    a_supply_low: assert property (vcc_under_i |=> !sys_reset_n_o)
        else $error("no reset on supply fault");
    a_monitor_low: assert property (adjustable_monitor_input_under_i |=> !sys_reset_n_o)
        else $error("no reset on monitor fault");
    a_release_hold: assert property ($fell(vcc_under_i) && !bad |=> !sys_reset_n_o [*8])
        else $error("early release");
    a_release_late: assert property ($rose(sys_reset_n_o) |-> quiet_q >= TIMEOUT_CYC - 2)
        else $error("release before timeout");
    a_glitch_quiet: assert property (idle && !long_hold_manual_input_a_driven_i && hi_q < 10
        |=> sys_reset_n_o)
        else $error("spurious reset");
    a_pulse_min: assert property ($fell(sys_reset_n_o) && !bad |=> !sys_reset_n_o [*8])
        else $error("short pulse");
    a_imm_fire: assert property (second_manual_input_i && hi_q == 10 && arm_q
        |=> !sys_reset_n_o)
        else $error("late immediate reset");
    a_hold_short: assert property (idle && !second_manual_input_i && hold_q < 1680 * TICK_CYC - 4
        && long_hold_manual_input_a_driven_i |=> sys_reset_n_o)
        else $error("reset before setup");
endmodule // sup_chk
`default_nettype wire

// ---- button_model.sv ----
`default_nettype none
module button_model (
    // Operator controls.
    input  wire logic press_i,
    input  wire logic float_i,
    // Line to the supervisor.
    output var  logic lvl_n_o,
    output var  logic driven_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // A floating line shows the active level, so only the drive flag keeps it idle.
    assign lvl_n_o  = float_i ? 1'b0 : ~press_i;
    assign driven_o = ~float_i;
endmodule // button_model
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
module tb
    import supervisor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 300;
    localparam int F = 40;
    localparam int S = 3360;
    logic clk, srst, vu, au, press, flt, imm;
    wire  lh_n, lh_drv, rst_n;
    int   n_errors, cmp_count, cyc, n;
    button_model button_model_inst (.press_i(press), .float_i(flt), .lvl_n_o(lh_n),
        .driven_o(lh_drv));
    supervisor_manual_reset_timer #(.VARIANT(VAR_IMMEDIATE), .SETUP_OPT(SETUP_T),
        .TIMEOUT_CYC(T), .FALL_CYC(F), .TICK_CYC(2)) supervisor_manual_reset_timer_inst (
        .sys_clk_i(clk), .srst_i(srst), .vcc_under_i(vu),
        .adjustable_monitor_input_under_i(au), .long_hold_manual_input_a_n_i(lh_n),
        .long_hold_manual_input_a_driven_i(lh_drv), .second_manual_input_i(imm),
        .second_manual_input_driven_i(1'b1), .sys_reset_n_o(rst_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_lvl(input logic v, input int max);
        n = 0;
        while (rst_n !== v && n < max) begin
            step(1);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_sup();
        for (int i = 0; i < 2; i++) begin
            {au, vu} = 2'h1 << i;
            step(2);
            check(rst_n, 1'b0);
            {au, vu} = 2'h0;
            wait_lvl(1, T + 20);
            check(n >= T && n <= T + 3, 1'b1);
        end
        $display("supply test done");
    endtask
    task automatic t_long();
        press = 1;
        step(S - 200);
        press = 0;
        step(T + 10);
        check(rst_n, 1'b1);
        flt = 1;
        press = 1;
        step(S + 50);
        check(rst_n, 1'b1);
        flt = 0;
        wait_lvl(0, S + 20);
        check(n >= S - 3 && n <= S + 4, 1'b1);
        step(20);
        vu = 1;
        step(3);
        vu = 0;
        wait_lvl(1, T + 20);
        check(n >= T && n <= T + 3, 1'b1);
        step(S + 50);
        check(rst_n, 1'b1);
        press = 0;
        step(10);
        press = 1;
        wait_lvl(0, S + 20);
        check(n >= S - 3 && n <= S + 4, 1'b1);
        wait_lvl(1, T + 20);
        check(n >= T - 1 && n <= T + 2, 1'b1);
        press = 0;
        $display("long hold test done");
    endtask
    task automatic t_imm();
        flt = 1;
        step(F + 5);
        imm = 1;
        step(10);
        imm = 0;
        step(5);
        check(rst_n, 1'b1);
        step(F + 5);
        imm = 1;
        wait_lvl(0, 20);
        check(n >= 11 && n <= 13, 1'b1);
        step(100);
        imm = 0;
        step(F + 5);
        imm = 1;
        step(T - 30);
        check(rst_n, 1'b0);
        wait_lvl(1, T);
        check(n > 30 && n < 50, 1'b1);
        imm = 0;
        step(F - 20);
        imm = 1;
        step(30);
        check(rst_n, 1'b1);
        $display("immediate test done");
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        {srst, vu, au, press, flt, imm} = 6'h20;
        step(16);
        srst = 0;
        step(2);
        t_sup();
        t_long();
        t_imm();
        finish_test();
    end
endmodule // tb
bind supervisor_manual_reset_timer sup_chk #(.TIMEOUT_CYC(TIMEOUT_CYC), .FALL_CYC(FALL_CYC),
    .TICK_CYC(TICK_CYC)) sup_chk_inst (.sys_clk_i, .srst_i, .vcc_under_i,
    .adjustable_monitor_input_under_i, .long_hold_manual_input_a_n_i,
    .long_hold_manual_input_a_driven_i, .second_manual_input_i, .sys_reset_n_o);
`default_nettype wire
